// File: src/data_alu_regs.vh
// Constants for the fractional multiply-accumulate data unit.
// Assumes a single core clock; included by the unit's design files.
`ifndef DATA_ALU_REGS_VH
`define DATA_ALU_REGS_VH

// Register select codes used by single-word bus moves
`define REG_X_LOW 4'h0
`define REG_X_HIGH 4'h1
`define REG_Y_LOW 4'h2
`define REG_Y_HIGH 4'h3
`define REG_A_LOW 4'h4
`define REG_A_UPPER 4'h5
`define REG_A_EXT 4'h6
`define REG_B_LOW 4'h7
`define REG_B_UPPER 4'h8
`define REG_B_EXT 4'h9
`define REG_A_WHOLE 4'hA
`define REG_B_WHOLE 4'hB

// Long (48-bit) move select codes
`define LONG_X 2'h0
`define LONG_Y 2'h1
`define LONG_A 2'h2
`define LONG_B 2'h3

// Accumulator portion selectors
`define PART_LOW 2'h0
`define PART_UPPER 2'h1
`define PART_EXT 2'h2
`define PART_WHOLE 2'h3

// Operation codes
`define OP_NOP 4'h0
`define OP_MPY 4'h1
`define OP_MAC 4'h2
`define OP_ADD 4'h3
`define OP_TFR 4'h4
`define OP_AND 4'h5
`define OP_OR 4'h6
`define OP_EOR 4'h7
`define OP_NOT 4'h8
`define OP_RND 4'h9
`define OP_CLR 4'hA

// Scaling modes
`define SCALE_NONE 2'h0
`define SCALE_DOWN 2'h1
`define SCALE_UP 2'h2

// Low bits discarded by rounding in each scaling mode
`define RND_MASK_NONE 56'h00000000FFFFFF
`define RND_MASK_DOWN 56'h00000001FFFFFF
`define RND_MASK_UP 56'h000000007FFFFF

// Reset values and limiting constants
`define RST_WORD 24'h000000
`define RST_ACC 56'h00000000000000
`define LIM_POS_HI 24'h7FFFFF
`define LIM_POS_LO 24'hFFFFFF
`define LIM_NEG_HI 24'h800000
`define LIM_NEG_LO 24'h000000

`endif

// File: src/bus_shift_limit.v
// Data bus shifter followed by a limiter for one accumulator source.
// Purely combinational; the caller registers what it drives out.
`include "data_alu_regs.vh"

module bus_shift_limit (
  input wire [55:0] acc_in, // Whole accumulator being read
  input wire [1:0] scale_mode, // Scaling mode from status
  output reg [23:0] word_hi, // Upper word after shift and limit
  output reg [23:0] word_lo, // Lower word after shift and limit
  output reg limited // High when a constant was substituted
);

  reg [55:0] shifted;

  // ----------------------------------------
  // Shift, then test and saturate
  // ----------------------------------------
  always @* begin
    case (scale_mode)
      `SCALE_DOWN: shifted = {acc_in[55], acc_in[55:1]};
      `SCALE_UP: shifted = {acc_in[54:0], 1'b0};
      default: shifted = acc_in;
    endcase
    // Overflow when extension and sign are not all alike
    limited = ~(&shifted[55:47] | ~|shifted[55:47]);
    if (limited) begin
      word_hi = acc_in[55] ? `LIM_NEG_HI : `LIM_POS_HI;
      word_lo = acc_in[55] ? `LIM_NEG_LO : `LIM_POS_LO;
    end else begin
      word_hi = shifted[47:24];
      word_lo = shifted[23:0];
    end
  end

endmodule

// File: src/fractional_mac_data_alu.v
// Data arithmetic unit: input registers, multiply-accumulator, logic
// unit, two 56-bit accumulators and two bus shifter/limiters.
// Assumes the sequencer supplies one operation and moves per cycle.
//
// What this block does
// - Four 24-bit inputs, also paired as 48-bit
// - Input registers readable back onto buses
// - Operands sampled before same-cycle bus loads
// - Three operands in, one 56-bit result
// - Signed fractional multiply from input registers
// - Product added to accumulator in one cycle
// - Extension adder; accumulators add or subtract
// - Multiply alone clears accumulator first
// - Results sign-extended and zero-filled
// - Reduce by truncation or convergent rounding
// - Rounding position follows scaling mode
// - Logic ops touch upper word only
// - Accumulator is extension, upper, lower
// - Extension reads sign-extended, upper writes ignored
// - Extension-in-use flag when extension significant
// - Word write fills upper, clears lower, extends
// - Long write fills both words, extends
// - Individual word writes never sign-extend
// - Whole reads scaled per scaling mode
// - Limiting changes bus value, not accumulator
// - Limit test follows the scaling shift
// - Only whole-accumulator sources shift or limit
// - Limit constant keeps sign, maximum magnitude
// - Sticky limit flag until software clears
// - Bus shifters pass, left or right
`include "data_alu_regs.vh"

module fractional_mac_data_alu (
  input wire core_clk, // Core clock
  input wire rst_b, // Synchronous reset, active low
  input wire [1:0] scale_mode, // Scaling mode bits of status
  input wire limit_clr, // Clears the sticky limit flag
  input wire op_valid, // Operation issued this cycle
  input wire [3:0] op_code, // Operation code
  input wire [1:0] op_src1, // First input register operand
  input wire [1:0] op_src2, // Second input register operand
  input wire op_dst_b, // Destination accumulator is B
  input wire op_neg, // Subtract instead of add
  input wire op_round, // Convergently round the result
  input wire [23:0] x_bus_in, // Data arriving on the X bus
  input wire [23:0] y_bus_in, // Data arriving on the Y bus
  input wire x_wr_en, // Write X bus data into a register
  input wire [3:0] x_wr_sel, // Register written from X bus
  input wire y_wr_en, // Write Y bus data into a register
  input wire [3:0] y_wr_sel, // Register written from Y bus
  input wire x_rd_en, // Read a register onto X bus
  input wire [3:0] x_rd_sel, // Register read onto X bus
  input wire y_rd_en, // Read a register onto Y bus
  input wire [3:0] y_rd_sel, // Register read onto Y bus
  input wire long_wr_en, // Long write, X upper and Y lower
  input wire [1:0] long_wr_sel, // Long register written
  input wire long_rd_en, // Long read, X upper and Y lower
  input wire [1:0] long_rd_sel, // Long register read
  output reg [23:0] x_data_bus, // Value driven on the X bus
  output reg [23:0] y_data_bus, // Value driven on the Y bus
  output reg ext_in_use, // Extension in use status flag
  output reg limit_flag // Sticky limiting status flag
);

  reg [23:0] input_x_low_q, input_x_low_d;
  reg [23:0] input_x_high_q, input_x_high_d;
  reg [23:0] input_y_low_q, input_y_low_d;
  reg [23:0] input_y_high_q, input_y_high_d;
  reg [55:0] acc_a_q, acc_a_d;
  reg [55:0] acc_b_q, acc_b_d;
  reg [55:0] op_res;
  reg op_we;
  reg [23:0] x_rd_d, y_rd_d;
  reg lim_hit;
  reg [55:0] dst_acc, oth_acc, prod_ext, sum;
  reg [47:0] prod;
  reg [23:0] src1, src2;
  reg [3:0] wsel;
  reg [23:0] wdat;
  reg wen;
  integer i;
  wire [55:0] xlim_src, ylim_src;
  wire [23:0] xlim_hi, xlim_lo, ylim_hi;
  wire xlim_hit, ylim_hit;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Input register read mux by two-bit code
  function [23:0] input_get(input [1:0] code, input [23:0] xl, input [23:0] xh,
                            input [23:0] yl, input [23:0] yh);
    begin
      case (code)
        2'h0: input_get = xl;
        2'h1: input_get = xh;
        2'h2: input_get = yl;
        default: input_get = yh;
      endcase
    end
  endfunction

  // Portion of an accumulator addressed by a select code
  function [1:0] sel_part(input [3:0] s);
    begin
      case (s)
        `REG_A_LOW, `REG_B_LOW: sel_part = `PART_LOW;
        `REG_A_UPPER, `REG_B_UPPER: sel_part = `PART_UPPER;
        `REG_A_EXT, `REG_B_EXT: sel_part = `PART_EXT;
        default: sel_part = `PART_WHOLE;
      endcase
    end
  endfunction

  // Writes one 24-bit value into an accumulator portion
  function [55:0] acc_put(input [55:0] cur, input [1:0] part, input [23:0] d);
    begin
      case (part)
        `PART_LOW: acc_put = {cur[55:24], d};
        `PART_UPPER: acc_put = {cur[55:48], d, cur[23:0]};
        `PART_EXT: acc_put = {d[7:0], cur[47:0]};
        default: acc_put = {{8{d[23]}}, d, 24'h000000};
      endcase
    end
  endfunction

  // Reads one accumulator portion as a 24-bit word
  function [23:0] acc_get(input [55:0] a, input [1:0] part);
    begin
      case (part)
        `PART_LOW: acc_get = a[23:0];
        `PART_UPPER: acc_get = a[47:24];
        default: acc_get = {{16{a[55]}}, a[55:48]};
      endcase
    end
  endfunction

  // High when the extension holds significant bits
  function ext_busy(input [55:0] a);
    begin
      ext_busy = ~(&a[55:47] | ~|a[55:47]);
    end
  endfunction

  // Round to nearest, ties to even, position set by scaling
  function [55:0] conv_round(input [55:0] v, input [1:0] m);
    reg [55:0] mask, half, s;
    begin
      case (m)
        `SCALE_DOWN: mask = `RND_MASK_DOWN;
        `SCALE_UP: mask = `RND_MASK_UP;
        default: mask = `RND_MASK_NONE;
      endcase
      half = (mask + 56'h00000000000001) >> 1;
      s = v + half;
      // A tie leaves the discarded bits zero: force the kept lsb even
      if ((s & mask) == 56'h00000000000000) begin
        s = s & ~(half << 1);
      end
      conv_round = s & ~mask;
    end
  endfunction

  // ----------------------------------------
  // Multiply-accumulate and logic unit
  // ----------------------------------------

  // Operands come from the registered values, so a same-cycle bus load
  // only takes effect for the next operation.
  always @* begin
    src1 = input_get(op_src1, input_x_low_q, input_x_high_q,
                     input_y_low_q, input_y_high_q);
    src2 = input_get(op_src2, input_x_low_q, input_x_high_q,
                     input_y_low_q, input_y_high_q);
    dst_acc = op_dst_b ? acc_b_q : acc_a_q;
    oth_acc = op_dst_b ? acc_a_q : acc_b_q;
    prod = $signed(src1) * $signed(src2);
    // Fractional alignment, shifted left one bit, zero-filled and sign-extended
    prod_ext = {{7{prod[47]}}, prod, 1'b0};
    sum = dst_acc;
    op_we = op_valid;
    case (op_code)
      `OP_MPY: sum = op_neg ? -prod_ext : prod_ext;
      `OP_MAC: sum = op_neg ? dst_acc - prod_ext : dst_acc + prod_ext;
      `OP_ADD: sum = op_neg ? dst_acc - oth_acc : dst_acc + oth_acc;
      `OP_TFR: sum = oth_acc;
      `OP_AND: sum = {dst_acc[55:48], dst_acc[47:24] & src1, dst_acc[23:0]};
      `OP_OR: sum = {dst_acc[55:48], dst_acc[47:24] | src1, dst_acc[23:0]};
      `OP_EOR: sum = {dst_acc[55:48], dst_acc[47:24] ^ src1, dst_acc[23:0]};
      `OP_NOT: sum = {dst_acc[55:48], ~dst_acc[47:24], dst_acc[23:0]};
      `OP_RND: sum = dst_acc;
      `OP_CLR: sum = `RST_ACC;
      default: op_we = 1'b0;
    endcase
    // Rounding applies only to arithmetic results
    if (op_round && (op_code == `OP_MPY || op_code == `OP_MAC ||
                     op_code == `OP_ADD || op_code == `OP_RND)) begin
      op_res = conv_round(sum, scale_mode);
    end else if (op_code == `OP_RND) begin
      op_res = conv_round(sum, scale_mode);
    end else begin
      op_res = sum;
    end
  end

  // ----------------------------------------
  // Register write path
  // ----------------------------------------

  // Y bus first, X bus second so X wins a double write; then long
  // moves; an operation result overrides a move to the same accumulator.
  always @* begin
    input_x_low_d = input_x_low_q;
    input_x_high_d = input_x_high_q;
    input_y_low_d = input_y_low_q;
    input_y_high_d = input_y_high_q;
    acc_a_d = acc_a_q;
    acc_b_d = acc_b_q;
    for (i = 0; i < 2; i = i + 1) begin
      wen = (i == 0) ? y_wr_en : x_wr_en;
      wsel = (i == 0) ? y_wr_sel : x_wr_sel;
      wdat = (i == 0) ? y_bus_in : x_bus_in;
      if (wen) begin
        case (wsel)
          `REG_X_LOW: input_x_low_d = wdat;
          `REG_X_HIGH: input_x_high_d = wdat;
          `REG_Y_LOW: input_y_low_d = wdat;
          `REG_Y_HIGH: input_y_high_d = wdat;
          `REG_A_LOW, `REG_A_UPPER, `REG_A_EXT, `REG_A_WHOLE:
            acc_a_d = acc_put(acc_a_d, sel_part(wsel), wdat);
          `REG_B_LOW, `REG_B_UPPER, `REG_B_EXT, `REG_B_WHOLE:
            acc_b_d = acc_put(acc_b_d, sel_part(wsel), wdat);
          default: ;
        endcase
      end
    end
    // Long writes: X bus carries the upper word, Y bus the lower
    if (long_wr_en) begin
      case (long_wr_sel)
        `LONG_X: begin
          input_x_high_d = x_bus_in;
          input_x_low_d = y_bus_in;
        end
        `LONG_Y: begin
          input_y_high_d = x_bus_in;
          input_y_low_d = y_bus_in;
        end
        `LONG_A: acc_a_d = {{8{x_bus_in[23]}}, x_bus_in, y_bus_in};
        default: acc_b_d = {{8{x_bus_in[23]}}, x_bus_in, y_bus_in};
      endcase
    end
    if (op_we) begin
      if (op_dst_b) begin
        acc_b_d = op_res;
      end else begin
        acc_a_d = op_res;
      end
    end
  end

  // ----------------------------------------
  // Bus shifter/limiters
  // ----------------------------------------

  // X limiter also serves long reads; Y limiter serves Y word reads
  assign xlim_src = (long_rd_en ? (long_rd_sel == `LONG_B) : (x_rd_sel == `REG_B_WHOLE))
                    ? acc_b_q : acc_a_q;
  assign ylim_src = (y_rd_sel == `REG_B_WHOLE) ? acc_b_q : acc_a_q;

  bus_shift_limit x_limiter (
    .acc_in(xlim_src),
    .scale_mode(scale_mode),
    .word_hi(xlim_hi),
    .word_lo(xlim_lo),
    .limited(xlim_hit)
  );

  bus_shift_limit y_limiter (
    .acc_in(ylim_src),
    .scale_mode(scale_mode),
    .word_hi(ylim_hi),
    .word_lo(),
    .limited(ylim_hit)
  );

  // ----------------------------------------
  // Register read path
  // ----------------------------------------

  // Picks each bus value; only whole-accumulator sources pass the limiter
  always @* begin
    x_rd_d = x_data_bus;
    y_rd_d = y_data_bus;
    lim_hit = 1'b0;
    if (long_rd_en) begin
      case (long_rd_sel)
        `LONG_X: begin
          x_rd_d = input_x_high_q;
          y_rd_d = input_x_low_q;
        end
        `LONG_Y: begin
          x_rd_d = input_y_high_q;
          y_rd_d = input_y_low_q;
        end
        default: begin
          x_rd_d = xlim_hi;
          y_rd_d = xlim_lo;
          lim_hit = xlim_hit;
        end
      endcase
    end else begin
      if (x_rd_en) begin
        case (x_rd_sel)
          `REG_X_LOW, `REG_X_HIGH, `REG_Y_LOW, `REG_Y_HIGH:
            x_rd_d = input_get(x_rd_sel[1:0], input_x_low_q, input_x_high_q,
                               input_y_low_q, input_y_high_q);
          `REG_A_LOW, `REG_A_UPPER, `REG_A_EXT:
            x_rd_d = acc_get(acc_a_q, sel_part(x_rd_sel));
          `REG_B_LOW, `REG_B_UPPER, `REG_B_EXT:
            x_rd_d = acc_get(acc_b_q, sel_part(x_rd_sel));
          `REG_A_WHOLE, `REG_B_WHOLE: begin
            x_rd_d = xlim_hi;
            lim_hit = xlim_hit;
          end
          default: x_rd_d = `RST_WORD;
        endcase
      end
      if (y_rd_en) begin
        case (y_rd_sel)
          `REG_X_LOW, `REG_X_HIGH, `REG_Y_LOW, `REG_Y_HIGH:
            y_rd_d = input_get(y_rd_sel[1:0], input_x_low_q, input_x_high_q,
                               input_y_low_q, input_y_high_q);
          `REG_A_LOW, `REG_A_UPPER, `REG_A_EXT:
            y_rd_d = acc_get(acc_a_q, sel_part(y_rd_sel));
          `REG_B_LOW, `REG_B_UPPER, `REG_B_EXT:
            y_rd_d = acc_get(acc_b_q, sel_part(y_rd_sel));
          `REG_A_WHOLE, `REG_B_WHOLE: begin
            y_rd_d = ylim_hi;
            lim_hit = lim_hit | ylim_hit;
          end
          default: y_rd_d = `RST_WORD;
        endcase
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------

  // All storage, the bus outputs and the status flags
  always @(posedge core_clk) begin
    if (!rst_b) begin
      input_x_low_q <= `RST_WORD;
      input_x_high_q <= `RST_WORD;
      input_y_low_q <= `RST_WORD;
      input_y_high_q <= `RST_WORD;
      acc_a_q <= `RST_ACC;
      acc_b_q <= `RST_ACC;
      x_data_bus <= `RST_WORD;
      y_data_bus <= `RST_WORD;
      ext_in_use <= 1'b0;
      limit_flag <= 1'b0;
    end else begin
      input_x_low_q <= input_x_low_d;
      input_x_high_q <= input_x_high_d;
      input_y_low_q <= input_y_low_d;
      input_y_high_q <= input_y_high_d;
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
      x_data_bus <= x_rd_d;
      y_data_bus <= y_rd_d;
      ext_in_use <= ext_busy(acc_a_d) | ext_busy(acc_b_d);
      // A new limit event wins over a same-cycle clear
      limit_flag <= lim_hit | (limit_flag & ~limit_clr);
    end
  end

endmodule

// File: verification/fractional_mac_data_alu_chk.sv
// Assertions on the data unit's bus moves, limiting and status flags.
// Sees only the unit's ports; bound to the unit at the foot of this file.
`include "data_alu_regs.vh"
module fractional_mac_data_alu_chk (
  input wire core_clk, // Core clock
  input wire rst_b, // Reset, active low
  input wire [1:0] scale_mode, op_src1, op_src2, long_wr_sel, long_rd_sel, // Selects
  input wire limit_clr, op_valid, op_dst_b, op_neg, op_round, // Controls
  input wire [3:0] op_code, x_wr_sel, y_wr_sel, x_rd_sel, y_rd_sel, // Codes
  input wire [23:0] x_bus_in, y_bus_in, x_data_bus, y_data_bus, // Data
  input wire x_wr_en, y_wr_en, x_rd_en, y_rd_en, long_wr_en, long_rd_en, // Strobes
  input wire ext_in_use, limit_flag // Status flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Cycles with only an X bus write, and X-only whole accumulator reads
  wire x_only = !y_wr_en && !long_wr_en && !op_valid;
  wire whole_x = x_rd_en && !long_rd_en && !y_rd_en &&
    (x_rd_sel == `REG_A_WHOLE || x_rd_sel == `REG_B_WHOLE);
  reg [23:0] xin_q1, xin_q2;
  // Bus data delayed two cycles
  always @(posedge core_clk) begin
    xin_q1 <= x_bus_in;
    xin_q2 <= xin_q1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_INPUT_READBACK: assert property (x_wr_en && x_wr_sel == `REG_X_LOW && x_only
    ##1 x_rd_en && x_rd_sel == `REG_X_LOW && !long_rd_en |=> x_data_bus == $past(x_bus_in, 2))
    else $error("input register read back differs from write");
  AST_EXT_SIGN: assert property (x_rd_en && !long_rd_en &&
    (x_rd_sel == `REG_A_EXT || x_rd_sel == `REG_B_EXT) |=> x_data_bus[23:8] == {16{x_data_bus[7]}})
    else $error("extension read not sign extended");
  AST_LIMIT_HOLD: assert property (limit_flag && !limit_clr |=> limit_flag)
    else $error("limit flag dropped without clear");
  AST_LIMIT_CLEAR: assert property (limit_clr && !x_rd_en && !y_rd_en && !long_rd_en
    |=> !limit_flag) else $error("limit flag not cleared");
  AST_LIMIT_WORD: assert property (whole_x && !limit_flag && !limit_clr ##1 limit_flag
    |-> x_data_bus == `LIM_POS_HI || x_data_bus == `LIM_NEG_HI) else $error("bad word limit");
  AST_LIMIT_LONG: assert property (long_rd_en && long_rd_sel[1] && !limit_flag && !limit_clr
    ##1 limit_flag |-> {x_data_bus, y_data_bus} == {`LIM_POS_HI, `LIM_POS_LO} ||
    {x_data_bus, y_data_bus} == {`LIM_NEG_HI, `LIM_NEG_LO}) else $error("bad long limit");
  AST_WORD_WRITE: assert property (x_wr_en && x_wr_sel == `REG_A_WHOLE && x_only ##1
    whole_x && x_rd_sel == `REG_A_WHOLE && scale_mode == `SCALE_NONE |=> x_data_bus == xin_q2)
    else $error("word write to accumulator not sign extended");
  AST_SCALE_DOWN: assert property (x_wr_en && x_wr_sel == `REG_A_WHOLE && x_only ##1
    whole_x && x_rd_sel == `REG_A_WHOLE && scale_mode == `SCALE_DOWN
    |=> x_data_bus == {xin_q2[23], xin_q2[23:1]}) else $error("scaled down read wrong");
  AST_EXT_FLAG: assert property (x_wr_en && x_bus_in[7:0] == 8'h01 && x_only &&
    (x_wr_sel == `REG_A_EXT || x_wr_sel == `REG_B_EXT) |=> ext_in_use)
    else $error("extension in use flag not set");
  // Main scenarios
  cover property (whole_x ##1 limit_flag);
  cover property (op_valid && op_code == `OP_MAC);
  cover property (long_rd_en ##1 limit_flag);
endmodule

bind fractional_mac_data_alu fractional_mac_data_alu_chk u_chk (
  .core_clk, .rst_b, .scale_mode, .op_src1, .op_src2, .long_wr_sel, .long_rd_sel, .limit_clr,
  .op_valid, .op_dst_b, .op_neg, .op_round, .op_code, .x_wr_sel, .y_wr_sel, .x_rd_sel,
  .y_rd_sel, .x_bus_in, .y_bus_in, .x_data_bus, .y_data_bus, .x_wr_en, .y_wr_en, .x_rd_en,
  .y_rd_en, .long_wr_en, .long_rd_en, .ext_in_use, .limit_flag
);

// File: verification/data_bus_far_side.sv
// Far side of the data unit: the core's X and Y data buses.
// A released bus shows the inverse of its last value, never a stale copy.
module data_bus_far_side (
  input wire core_clk, // Core clock
  input wire drive, // Buses driven this cycle
  input wire [23:0] x_val, // Value for the X bus
  input wire [23:0] y_val, // Value for the Y bus
  output logic [23:0] x_bus_in, // X bus into the unit
  output logic [23:0] y_bus_in // Y bus into the unit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] x_last = 24'h000000;
  logic [23:0] y_last = 24'h000000;
  // Remember what was last driven
  always @(posedge core_clk) begin
    if (drive) begin
      x_last <= x_val;
      y_last <= y_val;
    end
  end
  // Released lines carry the inverse pattern
  assign x_bus_in = drive ? x_val : ~x_last;
  assign y_bus_in = drive ? y_val : ~y_last;
endmodule

// File: verification/fractional_mac_data_alu_test.sv
// Self-checking bench for the data unit: moves, operations, limiting.
// Assumes the unit's header on the include path and a 25 MHz core clock.
`include "data_alu_regs.vh"
module fractional_mac_data_alu_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, limit_clr, op_valid, op_dst_b, op_neg, op_round, drive;
  logic x_wr_en, y_wr_en, x_rd_en, y_rd_en, long_wr_en, long_rd_en, ext_in_use, limit_flag;
  logic [1:0] scale_mode, op_src1, op_src2, long_wr_sel, long_rd_sel;
  logic [3:0] op_code, x_wr_sel, y_wr_sel, x_rd_sel, y_rd_sel;
  logic [23:0] x_bus_in, y_bus_in, x_val, y_val, x_data_bus, y_data_bus;
  int errors = 0;
  int comparisons = 0;
  fractional_mac_data_alu u_dut (.core_clk, .rst_b, .scale_mode, .limit_clr, .op_valid,
    .op_code, .op_src1, .op_src2, .op_dst_b, .op_neg, .op_round, .x_bus_in, .y_bus_in,
    .x_wr_en, .x_wr_sel, .y_wr_en, .y_wr_sel, .x_rd_en, .x_rd_sel, .y_rd_en, .y_rd_sel,
    .long_wr_en, .long_wr_sel, .long_rd_en, .long_rd_sel, .x_data_bus, .y_data_bus,
    .ext_in_use, .limit_flag);
  data_bus_far_side u_bus (.core_clk, .drive, .x_val, .y_val, .x_bus_in, .y_bus_in);
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Sets every strobe once for the coming edge, then lets that edge pass
  task automatic step(input logic [8:0] s);
    {x_wr_en, y_wr_en, x_rd_en, y_rd_en, long_wr_en, long_rd_en,
     op_valid, limit_clr, drive} = s;
    @(negedge core_clk);
  endtask
  task automatic wr(input logic yb, input logic [3:0] s, input logic [23:0] d);
    {x_val, y_val, x_wr_sel, y_wr_sel} = {d, d, s, s};
    step({!yb, yb, 7'h01});
  endtask
  task automatic rdc(input logic yb, input logic [3:0] s, input logic [23:0] exp);
    {x_rd_sel, y_rd_sel} = {s, s};
    step({2'h0, !yb, yb, 5'h00});
    chk({24'h000000, yb ? y_data_bus : x_data_bus}, {24'h000000, exp});
  endtask
  task automatic lw(input logic [1:0] s, input logic [23:0] hi, input logic [23:0] lo);
    {x_val, y_val, long_wr_sel} = {hi, lo, s};
    step(9'h011);
  endtask
  task automatic lrc(input logic [1:0] s, input logic [47:0] exp);
    long_rd_sel = s;
    step(9'h008);
    chk({x_data_bus, y_data_bus}, exp);
  endtask
  task automatic op(input logic [3:0] c, input logic [1:0] a, input logic [1:0] b);
    {op_code, op_src1, op_src2} = {c, a, b};
    step(9'h004);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_inputs;
    for (int i = 0; i < 4; i++) wr(i[0], i[3:0], 24'h1234A0 + 24'(i));
    for (int i = 0; i < 4; i++) rdc(!i[0], i[3:0], 24'h1234A0 + 24'(i));
    lrc(`LONG_X, {24'h1234A1, 24'h1234A0});
    lrc(`LONG_Y, {24'h1234A3, 24'h1234A2});
  endtask
  task automatic t_mac;
    wr(0, `REG_A_WHOLE, 24'h7FFFFF);
    wr(0, `REG_X_LOW, 24'h400000);
    rdc(0, `REG_X_LOW, 24'h400000);
    wr(1, `REG_Y_LOW, 24'h400000);
    // Operand reload in the same cycle as the multiply
    {x_val, x_wr_sel, op_code, op_src1, op_src2} = {24'h200000, `REG_X_LOW, `OP_MPY, 4'h2};
    step(9'h105);
    lrc(`LONG_A, {24'h200000, 24'h000000});
    op(`OP_MAC, 2'h0, 2'h2);
    lrc(`LONG_A, {24'h300000, 24'h000000});
    wr(1, `REG_Y_HIGH, 24'h800000);
    op_dst_b = 1'b1;
    op(`OP_MPY, 2'h0, 2'h3);
    op_dst_b = 1'b0;
    lrc(`LONG_B, {24'hE00000, 24'h000000});
    rdc(0, `REG_B_EXT, 24'hFFFFFF);
  endtask
  task automatic t_limit;
    wr(0, `REG_A_WHOLE, 24'h400000);
    wr(1, `REG_B_WHOLE, 24'h400000);
    op(`OP_ADD, 2'h0, 2'h0);
    chk(48'(ext_in_use), 48'h1);
    rdc(0, `REG_A_WHOLE, `LIM_POS_HI);
    rdc(1, `REG_A_UPPER, 24'h800000);
    rdc(1, `REG_A_EXT, 24'h000000);
    step(9'h000);
    chk(48'(limit_flag), 48'h1);
    step(9'h002);
    chk(48'(limit_flag), 48'h0);
    wr(0, `REG_B_EXT, 24'hABCD01);
    rdc(1, `REG_B_EXT, 24'h000001);
    lrc(`LONG_B, {`LIM_POS_HI, `LIM_POS_LO});
    wr(1, `REG_A_EXT, 24'h000080);
    rdc(0, `REG_A_WHOLE, `LIM_NEG_HI);
  endtask
  task automatic t_scale;
    wr(0, `REG_A_WHOLE, 24'h600000);
    rdc(0, `REG_A_WHOLE, 24'h600000);
    rdc(0, `REG_A_LOW, 24'h000000);
    scale_mode = `SCALE_DOWN;
    wr(0, `REG_A_WHOLE, 24'h600000);
    rdc(0, `REG_A_WHOLE, 24'h300000);
    rdc(1, `REG_A_UPPER, 24'h600000);
    scale_mode = `SCALE_UP;
    rdc(1, `REG_A_WHOLE, `LIM_POS_HI);
    scale_mode = `SCALE_NONE;
  endtask
  task automatic t_logic;
    logic [23:0] r[4] = '{24'h020406, 24'h1F3F5F, 24'h1D3B59, 24'hEDCBA9};
    wr(0, `REG_X_HIGH, 24'h0F0F0F);
    for (int k = 0; k < 4; k++) begin
      lw(`LONG_A, 24'h123456, 24'h654321);
      lrc(`LONG_A, {24'h123456, 24'h654321});
      op(`OP_AND + 4'(k), 2'h1, 2'h0);
      rdc(0, `REG_A_UPPER, r[k]);
      rdc(1, `REG_A_LOW, 24'h654321);
    end
  endtask
  task automatic t_round;
    logic [23:0] hi[5] = '{24'h100001, 24'h100000, 24'h100000, 24'h100001, 24'h100001};
    logic [23:0] lo[5] = '{24'h800000, 24'h800000, 24'h800001, 24'h000000, 24'h800000};
    logic [23:0] ex[5] = '{24'h100002, 24'h100000, 24'h100001, 24'h100000, 24'h200002};
    op_round = 1'b1;
    for (int k = 0; k < 5; k++) begin
      scale_mode = (k == 3) ? `SCALE_DOWN : `SCALE_NONE;
      lw(`LONG_A, hi[k], lo[k]);
      op((k == 4) ? `OP_MAC : `OP_RND, 2'h0, 2'h2);
      rdc(k[0], `REG_A_UPPER, ex[k]);
    end
    rdc(0, `REG_A_LOW, 24'h000000);
    op_round = 1'b0;
  endtask
  // Negated multiply, subtracting accumulate and add, transfer and clear
  task automatic t_neg;
    op_neg = 1'b1;
    op(`OP_MPY, 2'h0, 2'h2);
    lrc(`LONG_A, {24'hF00000, 24'h000000});
    op(`OP_MAC, 2'h0, 2'h2);
    lrc(`LONG_A, {24'hE00000, 24'h000000});
    op_dst_b = 1'b1;
    op(`OP_TFR, 2'h0, 2'h0);
    op_dst_b = 1'b0;
    lrc(`LONG_B, {24'hE00000, 24'h000000});
    op(`OP_ADD, 2'h0, 2'h0);
    lrc(`LONG_A, {24'h000000, 24'h000000});
    op_dst_b = 1'b1;
    op(`OP_CLR, 2'h0, 2'h0);
    {op_dst_b, op_neg} = 2'h0;
    rdc(1, `REG_B_EXT, 24'h000000);
    chk(48'(ext_in_use), 48'h0);
  endtask
  task automatic test_done;
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Reset, then the scenarios
  initial begin
    {rst_b, limit_clr, op_valid, op_dst_b, op_neg, op_round, drive} = '0;
    {x_wr_en, y_wr_en, x_rd_en, y_rd_en, long_wr_en, long_rd_en} = '0;
    {scale_mode, op_src1, op_src2, long_wr_sel, long_rd_sel, op_code} = '0;
    {x_wr_sel, y_wr_sel, x_rd_sel, y_rd_sel, x_val, y_val} = '0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    t_inputs;
    t_mac;
    t_limit;
    t_scale;
    t_logic;
    t_round;
    t_neg;
    test_done;
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    test_done;
  end
endmodule
